//--- common/quad_read_pkg.sv
// Shared constants and types for the quad I/O read link
package quad_read_pkg;
   // ***********************************************
   // Commands and frame layout
   // ***********************************************
   localparam logic [7:0] OPC_QUAD_READ = 8'heb;
   localparam logic [7:0] OPC_QUAD_READ_DTR = 8'hed;
   localparam logic [3:0] OPC_SPI_LAST = 4'h7;
   localparam logic [3:0] OPC_QPI_LAST = 4'h1;
   localparam logic [3:0] ADDR_MODE_LAST = 4'h7;
   localparam logic [3:0] ADDR_LAST = 4'h5;
   localparam logic [3:0] MODE_LAST = 4'h1;
   localparam logic [3:0] SPI_DUMMY_CLOCKS = 4'h4;
   localparam logic [3:0] MODE_CLOCKS_SDR = 4'h2;
   localparam logic [3:0] MODE_CLOCKS_DTR = 4'h1;
   localparam logic [1:0] BYPASS_KEEP = 2'b10;
   localparam logic [7:0] EXIT_CLOCKS_SDR = 8'h08;
   localparam logic [7:0] EXIT_CLOCKS_DTR = 8'h0a;
   localparam logic [23:0] WRAP_MIN_BYTES = 24'h8;
   // ***********************************************
   // Device configuration reset values
   // ***********************************************
   localparam logic [2:0] WRAP_RESET = 3'b001;
   localparam int WRAP_DIS_POS = 0;
   localparam logic [1:0] PARAM_RESET = 2'b00;
   // ***********************************************
   // Host register map
   // ***********************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_DATA = 4'hc;
   localparam int CTRL_START = 0;
   localparam int CTRL_DTR = 1;
   localparam int CTRL_QPI = 2;
   localparam int CTRL_SKIP = 3;
   localparam int CTRL_EXIT = 4;
   localparam int CTRL_LEN_LSB = 8;
   localparam int CTRL_MODE_LSB = 16;
   localparam int CTRL_DUMMY_LSB = 24;
   localparam int STATUS_BUSY = 0;
   localparam int STATUS_NEW = 1;
   localparam int STATUS_COUNT_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ***********************************************
   // Timing
   // ***********************************************
   localparam int MCLK_PERIOD_NS = 8;
   localparam int SCLK_PERIOD_NS = 128;
   localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
   // ***********************************************
   // State types
   // ***********************************************
   typedef enum logic [2:0] {D_IDLE, D_OPC, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_IGNORE} dev_state_t;
   typedef enum logic [3:0] {H_IDLE, H_OPC, H_ADDR, H_DUMMY, H_DATA, H_EXIT, H_STOP, H_GAP} host_state_t;

   function automatic logic [3:0] qpi_dummy_clocks(input logic [1:0] code);
      qpi_dummy_clocks = {1'b0, code, 1'b0} + 4'h2;
   endfunction
endpackage

//--- common/quad_link_if.sv
// Four-line serial link between host controller and flash device
`timescale 1ns/1ps
interface quad_link_if;
   logic sclk;
   logic cs_n;
   logic [3:0] host_out;
   logic [3:0] host_oe_n;
   logic [3:0] dev_out;
   logic [3:0] dev_oe_n;
   logic [3:0] io;

   // Undriven lines float high as with pull-ups
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         io[i] = !host_oe_n[i] ? host_out[i] : (!dev_oe_n[i] ? dev_out[i] : 1'b1);
      end
   end

   modport host (output sclk, output cs_n, output host_out, output host_oe_n, input io);
   modport dev (input sclk, input cs_n, input io, output dev_out, output dev_oe_n);
endinterface

//--- src/link_sync.sv
// Two-stage synchroniser for link pins
`timescale 1ns/1ps
module link_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Pins
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_st_t;

   sync_st_t st;
   sync_st_t next_st;

   always_comb
   begin
      next_st.s1 = pin_i;
      next_st.s2 = st.s1;
   end

   // Resets high so a released chip select looks idle
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         st <= '1;
      else
         st <= next_st;
   end

   assign sync_o = st.s2;
endmodule

//--- src/quad_read_device.sv
// Flash-side engine for single- and double-rate quad I/O reads
// Contract
// - Quad read uses four lines, four dummy clocks
// - Quad reads refused unless quad enable set
// - Mode byte follows address; upper nibble decides
// - Mode pair 10 skips opcode next command
// - Other mode pair values leave bypass mode
// - Host exits single-rate bypass with ones
// - Host exits double-rate bypass with ones
// - Host releases lines before first data
// - SPI-mode wrap inside section until deselect
// - Keep wrap disable bit and length field
// - Disable zero wraps; lengths 8 to 64
// - Wrap disabled after reset
// - Double-rate read behaves alike, needs enable
// - Double-rate moves address and data both edges
// - Four-wire mode dummy from parameter field
// - Mode clocks count within four-wire dummy
// - Opcode bypass also in four-wire mode
// - No wrapping in four-wire command mode
`timescale 1ns/1ps
module quad_read_device
   import quad_read_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Link
   quad_link_if.dev link,
   // Configuration
   input wire logic quad_lines_enable_bit_i,
   input wire logic four_wire_command_mode_i,
   input wire logic wrap_load_i,
   input wire logic [7:0] wrap_byte_i,
   input wire logic param_load_i,
   input wire logic [1:0] param_dummy_i,
   // Array read port
   output logic [23:0] rd_addr_o,
   input wire logic [7:0] rd_data_i,
   // Status
   output logic busy_o,
   output logic bypass_o,
   output logic refused_o
);
   typedef struct packed {
      dev_state_t state;
      logic sclk_q;
      logic armed;
      logic dtr;
      logic four_wire_command_mode;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [23:0] addr;
      logic [3:0] hold;
      logic high_next;
      logic bypass;
      logic bypass_dtr;
      logic [2:0] wrap_setting_bits;
      logic [1:0] param;
      logic [3:0] out;
      logic [3:0] oe_n;
      logic refused;
   } dev_st_t;

   localparam dev_st_t ST_RESET = '{state: D_IDLE, sclk_q: 1'b0, armed: 1'b0, dtr: 1'b0, four_wire_command_mode: 1'b0,
                                    cnt: 4'h0, sh: 8'h00, addr: 24'h000000, hold: 4'h0, high_next: 1'b1,
                                    bypass: 1'b0, bypass_dtr: 1'b0, wrap_setting_bits: WRAP_RESET,
                                    param: PARAM_RESET, out: 4'h0, oe_n: 4'hf, refused: 1'b0};

   dev_st_t st;
   dev_st_t next_st;
   logic [5:0] pins_s;
   logic sclk_s;
   logic cs_n_s;
   logic [3:0] io_s;

   // ***********************************************
   // Pin synchroniser
   // ***********************************************
   link_sync #(.WIDTH(6)) u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .pin_i({link.sclk, link.cs_n, link.io}),
      .sync_o(pins_s)
   );
   assign sclk_s = pins_s[5];
   assign cs_n_s = pins_s[4];
   assign io_s = pins_s[3:0];

   // ***********************************************
   // Read address advance
   // ***********************************************
   function automatic logic [23:0] next_read_addr(input logic [23:0] a, input logic en, input logic [1:0] len);
      logic [23:0] mask;
      logic [23:0] inc;
      mask = (WRAP_MIN_BYTES << len) - 24'h1;
      inc = a + 24'h1;
      if (en)
         next_read_addr = (a & ~mask) | (inc & mask);
      else
         next_read_addr = inc;
   endfunction

   // ***********************************************
   // Command sequencer
   // ***********************************************
   always_comb
   begin
      logic rise;
      logic fall;
      logic samp;
      logic wrap_en;
      logic [7:0] op;
      logic [7:0] mode;
      logic [3:0] dummy;
      rise = sclk_s && !st.sclk_q;
      fall = !sclk_s && st.sclk_q;
      // double-rate: both edges once a rise has passed
      samp = rise || (fall && st.dtr && st.armed);
      wrap_en = !st.four_wire_command_mode && !st.wrap_setting_bits[WRAP_DIS_POS];
      op = 8'h00;
      mode = 8'h00;
      dummy = 4'h0;
      next_st = st;
      next_st.sclk_q = sclk_s;
      next_st.refused = 1'b0;
      if (wrap_load_i)
         next_st.wrap_setting_bits = wrap_byte_i[6:4];
      if (param_load_i)
         next_st.param = param_dummy_i;
      if (cs_n_s)
      begin
         next_st.state = D_IDLE;
         next_st.oe_n = 4'hf;
      end
      else
      begin
         case (st.state)
            D_IDLE:
            begin
               next_st.four_wire_command_mode = four_wire_command_mode_i;
               next_st.armed = 1'b0;
               next_st.cnt = 4'h0;
               next_st.high_next = 1'b1;
               if (st.bypass && quad_lines_enable_bit_i)
               begin
                  next_st.state = D_ADDR;
                  next_st.dtr = st.bypass_dtr;
               end
               else
               begin
                  next_st.state = D_OPC;
                  next_st.bypass = 1'b0;
               end
            end
            D_OPC:
            begin
               if (rise)
               begin
                  op = st.four_wire_command_mode ? {st.sh[3:0], io_s} : {st.sh[6:0], io_s[0]};
                  next_st.sh = op;
                  next_st.cnt = st.cnt + 4'h1;
                  if (st.cnt == (st.four_wire_command_mode ? OPC_QPI_LAST : OPC_SPI_LAST))
                  begin
                     next_st.cnt = 4'h0;
                     next_st.armed = 1'b0;
                     if (quad_lines_enable_bit_i && (op == OPC_QUAD_READ || op == OPC_QUAD_READ_DTR))
                     begin
                        next_st.state = D_ADDR;
                        next_st.dtr = (op == OPC_QUAD_READ_DTR);
                     end
                     else
                     begin
                        next_st.state = D_IGNORE;
                        next_st.refused = 1'b1;
                     end
                  end
               end
            end
            D_ADDR:
            begin
               if (rise)
                  next_st.armed = 1'b1;
               if (samp)
               begin
                  next_st.addr = {st.addr[19:0], io_s};
                  next_st.cnt = st.cnt + 4'h1;
                  if (st.cnt == ADDR_LAST)
                  begin
                     next_st.state = D_MODE;
                     next_st.cnt = 4'h0;
                  end
               end
            end
            D_MODE:
            begin
               if (rise)
                  next_st.armed = 1'b1;
               if (samp)
               begin
                  mode = {st.sh[3:0], io_s};
                  next_st.sh = mode;
                  next_st.cnt = st.cnt + 4'h1;
                  if (st.cnt == MODE_LAST)
                  begin
                     next_st.bypass = (mode[5:4] == BYPASS_KEEP);
                     next_st.bypass_dtr = st.dtr;
                     // four dummy clocks in SPI mode
                     if (st.four_wire_command_mode)
                        dummy = qpi_dummy_clocks(st.param) - (st.dtr ? MODE_CLOCKS_DTR : MODE_CLOCKS_SDR);
                     else
                        dummy = SPI_DUMMY_CLOCKS;
                     next_st.cnt = dummy;
                     next_st.state = (dummy == 4'h0) ? D_DATA : D_DUMMY;
                  end
               end
            end
            D_DUMMY:
            begin
               if (rise)
               begin
                  next_st.cnt = st.cnt - 4'h1;
                  if (st.cnt == 4'h1)
                     next_st.state = D_DATA;
               end
            end
            D_DATA:
            begin
               if (fall || (st.dtr && rise))
               begin
                  next_st.oe_n = 4'h0;
                  if (st.high_next)
                  begin
                     next_st.out = rd_data_i[7:4];
                     next_st.hold = rd_data_i[3:0];
                     next_st.high_next = 1'b0;
                  end
                  else
                  begin
                     next_st.out = st.hold;
                     next_st.high_next = 1'b1;
                     next_st.addr = next_read_addr(st.addr, wrap_en, st.wrap_setting_bits[2:1]);
                  end
               end
            end
            D_IGNORE:
            begin
               next_st.oe_n = 4'hf;
            end
            default:
            begin
               next_st.state = D_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         st <= ST_RESET;
      else
         st <= next_st;
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign link.dev_out = st.out;
   assign link.dev_oe_n = st.oe_n;
   assign rd_addr_o = st.addr;
   assign busy_o = (st.state != D_IDLE);
   assign bypass_o = st.bypass;
   assign refused_o = st.refused;
endmodule

//--- src/quad_read_host.sv
// Host controller issuing quad I/O reads from register orders
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module quad_read_host
   import quad_read_pkg::*;
#(
   parameter int HALF = SCLK_HALF_CYCLES
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Status
   output logic busy_o,
   // Link
   quad_link_if.host link
);
   typedef struct packed {
      host_state_t state;
      logic [3:0] div;
      logic sclk;
      logic cs_n;
      logic armed;
      logic nib;
      logic [7:0] cnt;
      logic [7:0] bytes;
      logic [7:0] opc;
      logic [31:0] tx;
      logic [3:0] rx;
      logic [31:0] word;
      logic fresh;
      logic [31:0] ctrl;
      logic [23:0] addr;
      logic [3:0] out;
      logic [3:0] oe_n;
      logic [31:0] rdata;
   } host_st_t;

   localparam logic [3:0] DIV_LAST = 4'(HALF - 1);
   localparam logic [3:0] DIV_MID = 4'(HALF / 2 - 1);

   host_st_t st;
   host_st_t next_st;
   logic [3:0] io_s;

   link_sync #(.WIDTH(4)) u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .pin_i(link.io),
      .sync_o(io_s)
   );

   always_comb
   begin
      logic tick;
      logic mid;
      logic rise;
      logic fall;
      logic dtr;
      logic four_wire_command_mode;
      tick = (st.div == DIV_LAST);
      mid = (st.div == DIV_MID);
      rise = tick && !st.sclk;
      fall = tick && st.sclk;
      dtr = st.ctrl[CTRL_DTR];
      four_wire_command_mode = st.ctrl[CTRL_QPI];
      next_st = st;
      // ***********************************************
      // Register access
      // ***********************************************
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            REG_CTRL: next_st.rdata = st.ctrl;
            REG_ADDR: next_st.rdata = {8'h00, st.addr};
            REG_STATUS: next_st.rdata = {16'h0000, st.bytes, 6'h00, st.fresh, st.state != H_IDLE};
            REG_DATA:
            begin
               next_st.rdata = st.word;
               next_st.fresh = 1'b0;
            end
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
      // Orders while a frame runs are dropped
      if (reg_wr_i && st.state == H_IDLE)
      begin
         if (reg_addr_i == REG_ADDR)
            next_st.addr = reg_wdata_i[23:0];
         if (reg_addr_i == REG_CTRL)
         begin
            next_st.ctrl = reg_wdata_i & ~(32'h1 << CTRL_START);
            if (reg_wdata_i[CTRL_START])
            begin
               next_st.cs_n = 1'b0;
               next_st.div = 4'h0;
               next_st.cnt = 8'h00;
               next_st.bytes = 8'h00;
               next_st.armed = 1'b0;
               next_st.nib = 1'b0;
               next_st.opc = reg_wdata_i[CTRL_DTR] ? OPC_QUAD_READ_DTR : OPC_QUAD_READ;
               next_st.tx = {st.addr, reg_wdata_i[CTRL_MODE_LSB +: 8]};
               // ones on the lines leave bypass
               if (reg_wdata_i[CTRL_EXIT])
               begin
                  next_st.state = H_EXIT;
                  next_st.out = 4'hf;
                  next_st.oe_n = 4'h0;
                  next_st.cnt = reg_wdata_i[CTRL_DTR] ? EXIT_CLOCKS_DTR : EXIT_CLOCKS_SDR;
               end
               else
                  next_st.state = reg_wdata_i[CTRL_SKIP] ? H_ADDR : H_OPC;
            end
         end
      end
      // ***********************************************
      // Clock divider
      // ***********************************************
      if (st.state != H_IDLE)
         next_st.div = tick ? 4'h0 : st.div + 4'h1;
      if (tick && st.state inside {H_OPC, H_ADDR, H_DUMMY, H_DATA, H_EXIT})
         next_st.sclk = !st.sclk;
      // ***********************************************
      // Frame sequencer
      // ***********************************************
      case (st.state)
         H_IDLE:
         begin
            next_st.sclk = 1'b0;
         end
         H_OPC:
         begin
            if (mid && !st.sclk)
            begin
               next_st.out = four_wire_command_mode ? st.opc[7:4] : {3'b000, st.opc[7]};
               next_st.oe_n = four_wire_command_mode ? 4'h0 : 4'he;
            end
            if (rise)
            begin
               next_st.opc = four_wire_command_mode ? {st.opc[3:0], 4'h0} : {st.opc[6:0], 1'b0};
               next_st.cnt = st.cnt + 8'h01;
               if (st.cnt[3:0] == (four_wire_command_mode ? OPC_QPI_LAST : OPC_SPI_LAST))
               begin
                  next_st.state = H_ADDR;
                  next_st.cnt = 8'h00;
                  next_st.armed = 1'b0;
               end
            end
         end
         H_ADDR:
         begin
            if (mid && (!st.sclk || (dtr && st.armed)))
            begin
               next_st.out = st.tx[31:28];
               next_st.oe_n = 4'h0;
            end
            if (rise)
               next_st.armed = 1'b1;
            if (rise || (fall && dtr && st.armed))
            begin
               next_st.tx = {st.tx[27:0], 4'h0};
               next_st.cnt = st.cnt + 8'h01;
               if (st.cnt[3:0] == ADDR_MODE_LAST)
               begin
                  next_st.armed = 1'b0;
                  next_st.cnt = {4'h0, st.ctrl[CTRL_DUMMY_LSB +: 4]};
                  next_st.state = (st.ctrl[CTRL_DUMMY_LSB +: 4] == 4'h0) ? H_DATA : H_DUMMY;
               end
            end
         end
         H_DUMMY:
         begin
            // release half a phase after last mode edge
            // Letting go on that edge would spoil the sampled nibble
            if (mid)
               next_st.oe_n = 4'hf;
            if (rise)
            begin
               next_st.cnt = st.cnt - 8'h01;
               if (st.cnt == 8'h01)
                  next_st.state = H_DATA;
            end
         end
         H_DATA:
         begin
            // released before the first data edge
            if (mid)
               next_st.oe_n = 4'hf;
            if (rise)
               next_st.armed = 1'b1;
            if (rise || (fall && dtr && st.armed))
            begin
               next_st.rx = io_s;
               next_st.nib = !st.nib;
               if (st.nib)
               begin
                  next_st.word = {st.word[23:0], st.rx, io_s};
                  // Set wins over a same-cycle read clear
                  next_st.fresh = 1'b1;
                  next_st.bytes = st.bytes + 8'h01;
                  if (st.bytes == st.ctrl[CTRL_LEN_LSB +: 8])
                     next_st.state = H_STOP;
               end
            end
         end
         H_EXIT:
         begin
            // in double-rate mode the last two clocks ride the pull-ups
            // Device data phase would otherwise meet our drivers
            if (fall && dtr && st.cnt == EXIT_CLOCKS_DTR - EXIT_CLOCKS_SDR)
               next_st.oe_n = 4'hf;
            if (rise)
            begin
               next_st.cnt = st.cnt - 8'h01;
               if (st.cnt == 8'h01)
                  next_st.state = H_STOP;
            end
         end
         H_STOP:
         begin
            if (tick)
            begin
               if (st.sclk)
                  next_st.sclk = 1'b0;
               else
               begin
                  next_st.cs_n = 1'b1;
                  next_st.oe_n = 4'hf;
                  next_st.state = H_GAP;
               end
            end
         end
         H_GAP:
         begin
            if (tick)
               next_st.state = H_IDLE;
         end
         default:
         begin
            next_st.state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         st <= '{state: H_IDLE, cs_n: 1'b1, oe_n: 4'hf, ctrl: CTRL_RESET, default: '0};
      else
         st <= next_st;
   end

   assign link.sclk = st.sclk;
   assign link.cs_n = st.cs_n;
   assign link.host_out = st.out;
   assign link.host_oe_n = st.oe_n;
   assign reg_rdata_o = st.rdata;
   assign busy_o = (st.state != H_IDLE);
endmodule

//--- tb/quad_read_chk.sv
// Assertions on the quad link between host and device
`timescale 1ns/1ps
module quad_read_chk (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] host_oe_n,
   input wire logic [3:0] dev_oe_n
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   property p_one_drv; (host_oe_n | dev_oe_n) == 4'hf; endproperty
   a_one_drv: assert property (p_one_drv) else $error("io contention");
   property p_dev_four; dev_oe_n == 4'h0 || dev_oe_n == 4'hf; endproperty
   a_dev_four: assert property (p_dev_four) else $error("partial device drive");
   property p_dev_off; $rose(cs_n) |-> ##6 dev_oe_n == 4'hf; endproperty
   a_dev_off: assert property (p_dev_off) else $error("device drives after deselect");
   // Host must have let go well before the first data nibble
   property p_host_first; $fell(dev_oe_n[0]) |-> $past(host_oe_n, 2) == 4'hf; endproperty
   a_host_first: assert property (p_host_first) else $error("host still driving");
   property p_sclk_sel; $rose(sclk) |-> !cs_n; endproperty
   a_sclk_sel: assert property (p_sclk_sel) else $error("clock outside frame");
   property p_hi; $rose(sclk) |-> sclk [*8]; endproperty
   a_hi: assert property (p_hi) else $error("short high half");
   property p_lo; $fell(sclk) |-> !sclk [*8]; endproperty
   a_lo: assert property (p_lo) else $error("short low half");
   property p_cs_low; $fell(cs_n) |-> !cs_n [*8]; endproperty
   a_cs_low: assert property (p_cs_low) else $error("frame too short");
endmodule

//--- tb/quad_io_read_engine_tb_top.sv
// Bench joining host and device over the quad link
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module quad_io_read_engine_tb_top;
   import quad_read_pkg::*;
   logic mclk_i = 0;
   logic rst_i = 1;
   logic [3:0] ra = 0;
   logic [31:0] wd = 0;
   logic [31:0] rdat;
   logic wr = 0, rd = 0, qe = 1, four_wire_command_mode = 0, wl = 0, pl = 0, hbusy, dbusy, byp, refd;
   logic [7:0] wb = 0;
   logic [1:0] pd = 0;
   logic [23:0] da;
   int fail_count = 0, tests_run = 0, nref = 0;
   quad_link_if link ();
   quad_read_host u_quad_read_host (.mclk_i, .rst_i, .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdat), .busy_o(hbusy), .link(link.host));
   quad_read_device u_quad_read_device (.mclk_i, .rst_i, .link(link.dev), .quad_lines_enable_bit_i(qe),
      .four_wire_command_mode_i(four_wire_command_mode), .wrap_load_i(wl), .wrap_byte_i(wb), .param_load_i(pl),
      .param_dummy_i(pd), .rd_addr_o(da), .rd_data_i(da[7:0] ^ da[15:8]), .busy_o(dbusy), .bypass_o(byp),
      .refused_o(refd));
   quad_read_chk u_quad_read_chk (.mclk_i, .rst_i, .sclk(link.sclk), .cs_n(link.cs_n),
      .host_oe_n(link.host_oe_n), .dev_oe_n(link.dev_oe_n));
   always #4 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (refd === 1'b1) nref++;
   // Last four bytes of a burst, newest lowest
   function automatic logic [31:0] expw(input logic [23:0] a, input int len);
      logic [31:0] w;
      logic [23:0] b;
      w = 0;
      for (int i = 0; i < 4; i++)
      begin
         b = len ? 24'((a & ~(len - 1)) | ((a + i) & (len - 1))) : 24'(a + i);
         w = {w[23:0], b[7:0] ^ b[15:8]};
      end
      return w;
   endfunction
   function automatic logic [31:0] ctl(input logic d, q, s, x, input logic [7:0] m, input logic [3:0] dm);
      return {4'h0, dm, m, 8'h03, 3'h0, x, s, q, d, 1'b1};
   endfunction
   task automatic summarize();
      $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic acc(input logic [3:0] a, input logic [31:0] d, input logic w);
      @(posedge mclk_i);
      ra <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge mclk_i);
      wr <= 0;
      rd <= 0;
      @(posedge mclk_i);
   endtask
   task automatic run(input logic [31:0] c, input logic [23:0] a, input logic [31:0] e, input logic chk);
      int n;
      acc(REG_ADDR, {8'h00, a}, 1);
      acc(REG_CTRL, c, 1);
      n = 0;
      while (hbusy !== 1'b0 && n < 3000)
      begin
         @(posedge mclk_i);
         n++;
      end
      if (n == 3000)
      begin
         fail_count++;
         summarize();
      end
      // Device syncs deselect a few cycles late
      repeat (8) @(posedge mclk_i);
      `CHK(dbusy, 1'b0)
      if (chk)
      begin
         acc(REG_STATUS, 0, 0);
         `CHK(rdat[1:0], 2'b10)
         acc(REG_DATA, 0, 0);
         `CHK(rdat, e)
      end
   endtask
   initial
   begin
      int p;
      int len;
      logic d;
      logic q;
      logic [23:0] a;
      p = 0;
      len = 0;
      void'($urandom(32'hb8fd));
      repeat (6) @(posedge mclk_i);
      rst_i <= 0;
      acc(4'h2, 0, 0);
      `CHK(rdat, 32'h0)
      for (int k = 0; k < 10; k++)
      begin
         d = 1'($urandom);
         q = (k < 2) ? (k == 0) : (k >= 6);
         a = 24'($urandom) | 24'h3e;
         if (k > 1)
         begin
            wl <= 1;
            pl <= 1;
            wb <= {1'($urandom), 2'(k), k > 7, 4'($urandom)};
            pd <= 2'(k);
            @(posedge mclk_i);
            wl <= 0;
            pl <= 0;
            @(posedge mclk_i);
            p = pd;
            len = wb[4] ? 0 : 8 << wb[6:5];
         end
         four_wire_command_mode <= q;
         run(ctl(d, q, 0, 0, 8'($urandom) & 8'hcf, q ? 4'(2 * p + d) : SPI_DUMMY_CLOCKS), a, expw(a, q ? 0 : len), 1);
         `CHK(byp, 1'b0)
      end
      for (int j = 0; j < 3; j++)
      begin
         d = (j == 1);
         q = (j == 2);
         four_wire_command_mode <= q;
         run(ctl(d, q, 0, 0, 8'h2a, q ? 4'(2 * p + d) : 4'h4), a, expw(a, 0), 1);
         `CHK(byp, 1'b1)
         run(ctl(d, q, 1, 0, 8'h25, q ? 4'(2 * p + d) : 4'h4), a + 24'h1, expw(a + 24'h1, 0), 1);
         `CHK(byp, 1'b1)
         run(ctl(d, q, 0, 1, 8'h00, 4'h0), a, 0, 0);
         `CHK(byp, 1'b0)
      end
      four_wire_command_mode <= 0;
      run(ctl(0, 0, 0, 0, 8'h20, 4'h4), a, expw(a, 0), 1);
      run(ctl(0, 0, 1, 0, 8'h30, 4'h4), a, expw(a, 0), 1);
      `CHK(byp, 1'b0)
      qe <= 0;
      run(ctl(0, 0, 0, 0, 8'h00, 4'h4), a, 32'hffffffff, 1);
      `CHK(nref != 0, 1'b1)
      summarize();
   end
endmodule
